// file: urml_pkg.sv
// Constants shared by the register map and loopback block.
package urml_pkg;
  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [2:0] IDX_0 = 3'h0;
  localparam logic [2:0] IDX_1 = 3'h1;
  localparam logic [2:0] IDX_2 = 3'h2;
  localparam logic [2:0] IDX_3 = 3'h3;
  localparam logic [2:0] IDX_4 = 3'h4;
  localparam logic [2:0] IDX_5 = 3'h5;
  localparam logic [2:0] IDX_6 = 3'h6;
  localparam logic [2:0] IDX_7 = 3'h7;
  localparam int IDX_LSB = 2;
  localparam int MAP_TOP_LSB = 5;
  // ==========================================================================
  // Field positions and key values.
  localparam logic [7:0] ENH_KEY = 8'hbf;
  localparam int LC_DIV_BIT = 7;
  localparam int MC_LOOP_BIT = 4;
  localparam int MC_DTR_BIT = 0;
  localparam int MC_RTS_BIT = 1;
  localparam int MC_OP1_BIT = 2;
  localparam int MC_OP2_BIT = 3;
  localparam int EF_ENH_BIT = 4;
  localparam int FEAT_SEL_BIT = 6;
  // ==========================================================================
  // Reset values.
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // ==========================================================================
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Write handshake states.
  typedef enum logic [2:0] {
    URML_W_IDLE = 3'b001,
    URML_W_DO = 3'b010,
    URML_W_RESP = 3'b100
  } urml_wstate_t;
endpackage

// file: urml_pin_route.sv
// Serial and modem pin routing with internal loopback.
`timescale 1ns/1ps
`default_nettype none
module urml_pin_route
  import urml_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control
  input wire logic [7:0] i_modem_control,
  // Serial engine side
  input wire logic i_tsr_out,
  output logic o_rsr_in,
  // Line pins
  input wire logic i_rx_pin,
  output logic o_tx_pin,
  output logic o_rts_n,
  output logic o_dtr_n,
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_cd_n,
  input wire logic i_ri_n,
  // Active-high modem lines seen by the status logic: cd, ri, dsr, cts
  output logic [3:0] o_modem_lines
);
  logic loop;
  assign loop = i_modem_control[MC_LOOP_BIT]; // R01

  // ==========================================================================
  // Pin drive. Every path is registered, so loopback adds one cycle of delay
  // on the serial path; that is far below one bit time.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_tx_pin <= 1'b1;
      o_rts_n <= 1'b1;
      o_dtr_n <= 1'b1;
      o_rsr_in <= 1'b1;
    end else begin
      o_tx_pin <= loop ? 1'b1 : i_tsr_out; // R03
      o_rts_n <= loop ? 1'b1 : ~i_modem_control[MC_RTS_BIT]; // R04
      o_dtr_n <= loop ? 1'b1 : ~i_modem_control[MC_DTR_BIT]; // R04
      o_rsr_in <= loop ? i_tsr_out : i_rx_pin; // R02 R06
    end
  end

  // ==========================================================================
  // Modem inputs, replaced by the control bits in loopback.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_modem_lines <= 4'h0;
    end else if (loop) begin
      o_modem_lines <= {i_modem_control[MC_OP2_BIT], i_modem_control[MC_OP1_BIT],
                        i_modem_control[MC_DTR_BIT], i_modem_control[MC_RTS_BIT]}; // R05 R08
    end else begin
      o_modem_lines <= {~i_cd_n, ~i_ri_n, ~i_dsr_n, ~i_cts_n};
    end
  end
endmodule
`default_nettype wire

// file: urml_top.sv
// UART register map with banked decode over AXI4-Lite and internal loopback.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R01 - Modem control bit 4 set enters loopback; cleared leaves it.
// R02 - Loopback feeds transmit shift output straight into receive shift input.
// R03 - Loopback holds the TX pin at mark, high.
// R04 - Loopback drives RTS and DTR pins de-asserted regardless of control bits.
// R05 - Loopback ignores CTS, DSR, CD and RI input pins.
// R06 - All other UART functions keep working during loopback.
// R07 - Line side must hold RX high during loopback to avoid false break.
// R08 - Loopback reflects modem control outputs into modem status inputs.
// R09 - Divisor bit set, not keyed: addresses 0 and 1 are divisor bytes.
// R10 - Address 2 is fractional divisor when divisor bit, not keyed, enhanced on.
// R11 - Divisor bit set, not keyed, divisor zero: reads give revision and identity.
// R12 - Divisor bit clear: address 0 reads receive and writes transmit holding.
// R13 - Address 2 reads interrupt status, writes FIFO control, under bank conditions.
// R14 - Address 3 is always line control; address 4 is modem control when not keyed.
// R15 - Address 5 reads line status whenever not keyed.
// R16 - Address 6 reads modem status; writes extra settings if enhanced, not keyed.
// R17 - Address 7 is scratch, or level count and mode select by feature bit 6.
// R18 - Key 0xbf shows feature, enhanced function, resume and pause characters.
// R19 - In the keyed bank address 0 reads level count, writes trigger level.
module urml_top
  import urml_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [7:0] REVISION = 8'h01,  // Value is arbitrary.
  parameter logic [7:0] IDENTITY = 8'h5a   // Value is arbitrary.
)(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial engine
  input wire logic [7:0] i_receive_holding,
  input wire logic [7:0] i_interrupt_status,
  input wire logic [7:0] i_line_status,
  input wire logic [7:0] i_fifo_level_count,
  input wire logic i_tsr_out,
  output logic o_rsr_in,
  output logic o_tx_hold_wr,
  output logic o_rx_hold_rd,
  output logic o_fifo_ctl_wr,
  output logic [7:0] o_wr_data,
  output logic [7:0] o_line_control,
  output logic [15:0] o_divisor,
  output logic o_loopback,
  // Line pins
  input wire logic i_rx_pin,
  output logic o_tx_pin,
  output logic o_rts_n,
  output logic o_dtr_n,
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_cd_n,
  input wire logic i_ri_n
);
  // ==========================================================================
  // Register storage.
  logic [7:0] linectl_q, mdmctl_q, irqen_q, div_lo_q, div_hi_q, div_frac_q, enhfn_q, featctl_q;
  logic [7:0] xon1_q, xon2_q, xoff1_q, xoff2_q, scratch_q, modesel_q, trglvl_q, mxs_q;
  logic [3:0] mdelta_q, mline_q;
  logic [3:0] mlines;

  logic keyed, dlab, enh, dzero;
  assign keyed = (linectl_q == ENH_KEY);
  assign dlab = linectl_q[LC_DIV_BIT];
  assign enh = enhfn_q[EF_ENH_BIT];
  assign dzero = (div_lo_q == ZERO_BYTE) && (div_hi_q == ZERO_BYTE);

  // ==========================================================================
  // Write channel. Address and data are latched independently so that the
  // master may offer them in either order.
  urml_wstate_t wst_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wdo;
  logic [2:0] widx;
  logic wmap;

  assign wdo = (wst_q == URML_W_DO);
  assign widx = awaddr_q[IDX_LSB +: 3];
  assign wmap = (awaddr_q[ADDR_W-1:MAP_TOP_LSB] == '0);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wst_q <= URML_W_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wst_q)
        URML_W_IDLE: begin
          s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
          s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
          if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
          end
          if ((aw_have_q || (s_axi_awvalid && s_axi_awready)) &&
              (w_have_q || (s_axi_wvalid && s_axi_wready))) begin
            wst_q <= URML_W_DO;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
          end
        end
        URML_W_DO: begin
          aw_have_q <= 1'b0;
          w_have_q <= 1'b0;
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= wmap ? RESP_OKAY : RESP_SLVERR;
          wst_q <= URML_W_RESP;
        end
        URML_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wst_q <= URML_W_IDLE;
          end
        end
        default: begin
          wst_q <= URML_W_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Banked write decode.
  logic we;
  assign we = wdo && wmap && wlane_q;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      linectl_q <= REG_RST; mdmctl_q <= REG_RST; irqen_q <= REG_RST; div_lo_q <= REG_RST;
      div_hi_q <= REG_RST; div_frac_q <= REG_RST; enhfn_q <= REG_RST; featctl_q <= REG_RST;
      xon1_q <= REG_RST; xon2_q <= REG_RST; xoff1_q <= REG_RST; xoff2_q <= REG_RST;
      scratch_q <= REG_RST; modesel_q <= REG_RST; trglvl_q <= REG_RST; mxs_q <= REG_RST;
    end else if (we) begin
      case (widx)
        IDX_0: begin
          if (keyed) trglvl_q <= wbyte_q; // R19
          else if (dlab) div_lo_q <= wbyte_q; // R09
        end
        IDX_1: begin
          if (keyed) featctl_q <= wbyte_q; // R18
          else if (dlab) div_hi_q <= wbyte_q; // R09
          else irqen_q <= wbyte_q;
        end
        IDX_2: begin
          if (keyed) enhfn_q <= wbyte_q; // R18
          else if (dlab && enh) div_frac_q <= wbyte_q; // R10
        end
        IDX_3: linectl_q <= wbyte_q; // R14
        IDX_4: begin
          if (keyed) xon1_q <= wbyte_q; // R18
          else mdmctl_q <= wbyte_q; // R14 R01
        end
        IDX_5: begin
          if (keyed) xon2_q <= wbyte_q; // R18
        end
        IDX_6: begin
          if (keyed) xoff1_q <= wbyte_q; // R18
          else if (enh) mxs_q <= wbyte_q; // R16
        end
        IDX_7: begin
          if (keyed) xoff2_q <= wbyte_q; // R18
          else if (featctl_q[FEAT_SEL_BIT]) modesel_q <= wbyte_q; // R17
          else scratch_q <= wbyte_q; // R17
        end
        default: begin
          scratch_q <= scratch_q;
        end
      endcase
    end
  end

  // Strobes towards the serial engine, one cycle each.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_tx_hold_wr <= 1'b0;
      o_fifo_ctl_wr <= 1'b0;
      o_wr_data <= 8'h00;
    end else begin
      o_tx_hold_wr <= we && (widx == IDX_0) && !keyed && !dlab; // R12
      o_fifo_ctl_wr <= we && (widx == IDX_2) && !keyed && !(dlab && enh); // R13
      if (we) o_wr_data <= wbyte_q;
    end
  end

  // ==========================================================================
  // Read channel: one read at a time, answered the cycle after the address.
  logic [2:0] ridx;
  logic rmap, rtake;
  logic [7:0] rbyte;
  assign ridx = s_axi_araddr[IDX_LSB +: 3];
  assign rmap = (s_axi_araddr[ADDR_W-1:MAP_TOP_LSB] == '0);
  assign rtake = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rbyte = 8'h00;
    case (ridx)
      IDX_0: begin
        if (keyed) rbyte = i_fifo_level_count; // R19
        else if (dlab) rbyte = dzero ? REVISION : div_lo_q; // R09 R11
        else rbyte = i_receive_holding; // R12
      end
      IDX_1: begin
        if (keyed) rbyte = featctl_q; // R18
        else if (dlab) rbyte = dzero ? IDENTITY : div_hi_q; // R09 R11
        else rbyte = irqen_q;
      end
      IDX_2: begin
        if (keyed) rbyte = enhfn_q; // R18
        else if (dlab && enh) rbyte = div_frac_q; // R10
        else rbyte = i_interrupt_status; // R13
      end
      IDX_3: rbyte = linectl_q; // R14
      IDX_4: rbyte = keyed ? xon1_q : mdmctl_q; // R14 R18
      IDX_5: rbyte = keyed ? xon2_q : i_line_status; // R15
      IDX_6: rbyte = keyed ? xoff1_q : {mline_q, mdelta_q}; // R16
      IDX_7: begin
        if (keyed) rbyte = xoff2_q; // R18
        else if (featctl_q[FEAT_SEL_BIT]) rbyte = i_fifo_level_count; // R17
        else rbyte = scratch_q; // R17
      end
      default: rbyte = 8'h00;
    endcase
  end

  logic mstat_rd;
  assign mstat_rd = rtake && rmap && (ridx == IDX_6) && !keyed;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      o_rx_hold_rd <= 1'b0;
    end else begin
      o_rx_hold_rd <= rtake && rmap && (ridx == IDX_0) && !keyed && !dlab; // R12
      if (rtake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rmap ? rbyte : 8'h00};
        s_axi_rresp <= rmap ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Modem status. A change in the same cycle as the clearing read still sets
  // its delta bit, so no edge is lost.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      mline_q <= 4'h0;
      mdelta_q <= 4'h0;
    end else begin
      mline_q <= mlines;
      mdelta_q <= (mstat_rd ? 4'h0 : mdelta_q) | (mlines ^ mline_q); // R08
    end
  end

  // ==========================================================================
  // Configuration towards the engine; the pin router takes mdmctl_q directly.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_line_control <= REG_RST;
      o_divisor <= 16'h0000;
      o_loopback <= 1'b0;
    end else begin
      o_line_control <= linectl_q;
      o_divisor <= {div_hi_q, div_lo_q};
      o_loopback <= mdmctl_q[MC_LOOP_BIT]; // R01
    end
  end

  urml_pin_route u_route (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_modem_control(mdmctl_q),
    .i_tsr_out(i_tsr_out),
    .o_rsr_in(o_rsr_in),
    .i_rx_pin(i_rx_pin),
    .o_tx_pin(o_tx_pin),
    .o_rts_n(o_rts_n),
    .o_dtr_n(o_dtr_n),
    .i_cts_n(i_cts_n),
    .i_dsr_n(i_dsr_n),
    .i_cd_n(i_cd_n),
    .i_ri_n(i_ri_n),
    .o_modem_lines(mlines)
  );
endmodule
`default_nettype wire

// file: urml_assertions.sv
// Concurrent checks on the register map and loopback ports.
`timescale 1ns/1ps
`default_nettype none
module urml_checker
  import urml_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [7:0] REVISION = 8'h01
)(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Bus
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  // Engine and pins
  input wire logic [7:0] i_receive_holding,
  input wire logic [7:0] i_line_status,
  input wire logic [7:0] i_fifo_level_count,
  input wire logic i_tsr_out,
  input wire logic o_rsr_in,
  input wire logic o_fifo_ctl_wr,
  input wire logic [7:0] o_line_control,
  input wire logic [15:0] o_divisor,
  input wire logic o_loopback,
  input wire logic o_tx_pin,
  input wire logic o_rts_n,
  input wire logic o_dtr_n
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic [3:0] rd_at;
  logic keyed;
  logic loop3;
  // Index 8 means no mapped read is taken; the one-cycle copies lag, so loop needs three.
  assign rd_at = (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:5] == '0) ?
                 {1'b0, s_axi_araddr[4:2]} : 4'h8;
  assign keyed = o_line_control == ENH_KEY;
  assign loop3 = o_loopback;
  // ==========================================================================
  // Assertions
  a_tx_mark: assert property (loop3 && $past(loop3) |-> o_tx_pin)
    else $error("tx pin left mark in loopback");
  a_modem_out_idle: assert property (loop3 && $past(loop3) |-> o_rts_n && o_dtr_n)
    else $error("modem outputs asserted in loopback");
  a_loop_path: assert property (loop3 && $past(loop3) && $past(loop3, 2)
    |-> o_rsr_in == $past(i_tsr_out))
    else $error("receive input not fed from transmit output");
  a_rx_hold_read: assert property (rd_at == 4'h0 && !o_line_control[LC_DIV_BIT]
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(i_receive_holding))
    else $error("receive holding read wrong");
  a_revision_read: assert property (rd_at == 4'h0 && o_line_control[LC_DIV_BIT] && !keyed
    && o_divisor == 16'h0 |=> s_axi_rdata[7:0] == REVISION)
    else $error("revision read wrong");
  a_status_read: assert property (rd_at == 4'h5 && !keyed
    |=> s_axi_rdata[7:0] == $past(i_line_status))
    else $error("line status read wrong");
  a_level_read: assert property (rd_at == 4'h0 && keyed
    |=> s_axi_rdata[7:0] == $past(i_fifo_level_count))
    else $error("level count read wrong");
  a_fifo_ctrl_pulse: assert property (o_fifo_ctl_wr |-> $rose(s_axi_bvalid) && !keyed)
    else $error("fifo control strobe out of place");
  c_loop: cover property (loop3 && o_tx_pin);
  c_fifo_ctl: cover property (o_fifo_ctl_wr);
  c_rev: cover property (rd_at == 4'h0 && o_line_control[LC_DIV_BIT]);
endmodule
bind urml_top urml_checker #(.ADDR_W(ADDR_W), .REVISION(REVISION)) u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .i_receive_holding(i_receive_holding), .i_line_status(i_line_status),
  .i_fifo_level_count(i_fifo_level_count), .i_tsr_out(i_tsr_out), .o_rsr_in(o_rsr_in),
  .o_fifo_ctl_wr(o_fifo_ctl_wr), .o_line_control(o_line_control), .o_divisor(o_divisor),
  .o_loopback(o_loopback), .o_tx_pin(o_tx_pin), .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n));
`default_nettype wire

// file: urml_line_model.sv
// Line side model: keeps RX at mark and drives the modem inputs.
`timescale 1ns/1ps
`default_nettype none
module urml_line_model (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_wiggle,
  // Line pins
  output logic o_rx_pin,
  output logic [3:0] o_modem_n
);
  // ==========================================================================
  // Pins
  assign o_rx_pin = 1'b1;
  // Inactive high unless told to toggle, so the idle pins raise no deltas.
  initial begin
    o_modem_n = 4'hf;
  end
  always @(posedge i_clk) begin
    o_modem_n <= i_wiggle ? 4'($urandom) : 4'hf;
  end
endmodule
`default_nettype wire

// file: urml_top_tb_top.sv
// Self-checking bench for the register map and loopback block.
`timescale 1ns/1ps
`default_nettype none
module urml_top_tb_top;
  import urml_pkg::*;
  // ==========================================================================
  // Signals
  localparam logic [7:0] REV = 8'h01;  // Value is arbitrary.
  localparam logic [7:0] ID = 8'h5a;   // Value is arbitrary.
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic tsr = 1'b1, wig = 1'b0;
  logic [7:0] awa = 8'h0, ara = 8'h0, rxh = 8'h0, ists = 8'h0, lsts = 8'h0, flc = 8'h0;
  int n_txw = 0;
  int n_rxr = 0;
  int n_fcw = 0;
  logic [31:0] wd = 32'h0;
  logic awr, wrdy, arr, bv, rv, rsr, thw, rhd, fcw, loop, rx, tx, rts_n, dtr_n;
  logic [3:0] mdm_n;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  logic [7:0] wdat, lc, b, c;
  logic [15:0] dv;
  int err_count = 0;
  int checks_done = 0;
  logic [7:0] exp_q[$];
  initial begin
    forever #10 clk = ~clk;
  end
  urml_top #(.ADDR_W(8), .REVISION(REV), .IDENTITY(ID)) DUT (
    .i_clk(clk), .i_resetn(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .i_receive_holding(rxh),
    .i_interrupt_status(ists), .i_line_status(lsts), .i_fifo_level_count(flc),
    .i_tsr_out(tsr), .o_rsr_in(rsr), .o_tx_hold_wr(thw), .o_rx_hold_rd(rhd),
    .o_fifo_ctl_wr(fcw),
    .o_wr_data(wdat), .o_line_control(lc), .o_divisor(dv), .o_loopback(loop),
    .i_rx_pin(rx), .o_tx_pin(tx), .o_rts_n(rts_n), .o_dtr_n(dtr_n), .i_cts_n(mdm_n[0]),
    .i_dsr_n(mdm_n[1]), .i_cd_n(mdm_n[2]), .i_ri_n(mdm_n[3]));
  urml_line_model u_line (.i_clk(clk), .i_wiggle(wig), .o_rx_pin(rx), .o_modem_n(mdm_n));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] er);
    logic ad_done;
    logic d_done;
    ad_done = 1'b0;
    d_done = 1'b0;
    @(posedge clk);
    awa <= ad;
    wd <= {24'($urandom), d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ad_done && d_done)) begin
      @(posedge clk);
      if (awv && awr) begin
        ad_done = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wrdy) begin
        d_done = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    bry <= 1'b0;
    chk({6'h0, br}, {6'h0, er});
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    ara <= ad;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rry <= 1'b0;
  endtask
  task automatic pins(input logic [2:0] e);
    repeat (3) @(posedge clk);
    chk({5'h0, tx, rts_n, dtr_n}, {5'h0, e});
  endtask
  // ==========================================================================
  // Monitor and stimulus
  always @(posedge clk) begin
    if (rv && rry) begin
      chk(rdat[7:0], exp_q.pop_front());
    end
    if (thw) begin
      n_txw++;
      chk(wdat, 8'h55);
    end
    if (fcw) begin
      n_fcw++;
      chk(wdat, 8'h07);
    end
    if (rhd) begin
      n_rxr++;
    end
    tsr <= wig ? 1'($urandom) : 1'b1;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    void'($urandom(76910));
    @(posedge clk);
    rxh <= 8'($urandom);
    ists <= 8'($urandom);
    lsts <= 8'($urandom);
    flc <= 8'($urandom);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h0c, 8'h00);
    rd(8'h00, rxh);
    rd(8'h08, ists);
    rd(8'h14, lsts);
    rd(8'h18, 8'h00);
    wr(8'h00, 8'h55, RESP_OKAY);
    wr(8'h08, 8'h07, RESP_OKAY);
    b = 8'($urandom);
    wr(8'h1c, b, RESP_OKAY);
    rd(8'h1c, b);
    wr(8'h20, b, RESP_SLVERR);
    $display("test normal bank done");
    wr(8'h0c, 8'h80, RESP_OKAY);
    rd(8'h00, REV);
    rd(8'h04, ID);
    b = 8'($urandom) | 8'h01;
    c = 8'($urandom);
    wr(8'h00, b, RESP_OKAY);
    wr(8'h04, c, RESP_OKAY);
    rd(8'h00, b);
    rd(8'h04, c);
    chk(dv[7:0], b);
    chk(dv[15:8], c);
    $display("test divisor bank done");
    wr(8'h0c, ENH_KEY, RESP_OKAY);
    rd(8'h00, flc);
    chk(lc, ENH_KEY);
    wr(8'h08, 8'h10, RESP_OKAY);
    rd(8'h08, 8'h10);
    wr(8'h04, 8'h40, RESP_OKAY);
    rd(8'h04, 8'h40);
    for (int i = 4; i < 8; i++) begin
      wr(8'(4 * i), 8'(33 * i), RESP_OKAY);
      rd(8'(4 * i), 8'(33 * i));
    end
    wr(8'h0c, 8'h80, RESP_OKAY);
    wr(8'h08, 8'h35, RESP_OKAY);
    rd(8'h08, 8'h35);
    wr(8'h0c, 8'h03, RESP_OKAY);
    rd(8'h1c, flc);
    $display("test enhanced bank done");
    wr(8'h10, 8'h03, RESP_OKAY);
    pins(3'b100);
    wr(8'h10, 8'h13, RESP_OKAY);
    wig <= 1'b1;
    pins(3'b111);
    chk({7'h0, loop}, 8'h01);
    rd(8'h18, 8'h33);
    rd(8'h18, 8'h30);
    rd(8'h14, lsts);
    wig <= 1'b0;
    wr(8'h10, 8'h03, RESP_OKAY);
    pins(3'b100);
    chk({7'h0, loop}, 8'h00);
    chk(8'(n_txw), 8'h01);
    chk(8'(n_rxr), 8'h01);
    chk(8'(n_fcw), 8'h01);
    $display("test loopback done");
    summarize();
  end
endmodule
`default_nettype wire
